// *** common/sensor_pll_page_pkg.sv ***
package sensor_pll_page_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // Register offsets.
  localparam logic [7:0] CLOCK_OFFS     = 8'h65;
  localparam logic [7:0] PLL_ONE_OFFS   = 8'h66;
  localparam logic [7:0] PLL_TWO_OFFS   = 8'h67;
  localparam logic [7:0] PAGE_OFFS      = 8'hF0;
  localparam logic [7:0] BYTE_PORT_OFFS = 8'hF1;
  localparam logic [7:0] CONTEXT_OFFS   = 8'hF2;
  localparam logic [7:0] IDENT_OFFS     = 8'hFF;
  localparam logic [7:0] RESTART_OFFS   = 8'h0D;

  // Clock register fields.
  localparam int CLK_BYPASS_BIT  = 15;
  localparam int CLK_PLLPD_BIT   = 14;
  localparam int CLK_STBYPD_BIT  = 13;
  localparam int CLK_SHIP_BIT    = 0;
  localparam logic [15:0] CLOCK_RESET = 16'hE000;
  localparam logic [15:0] CLOCK_MASK  = 16'hE007;

  // PLL fields.
  localparam logic [15:0] PLL_ONE_RESET = 16'h1000;
  localparam logic [15:0] PLL_ONE_MASK  = 16'hFF3F;
  localparam logic [15:0] PLL_TWO_RESET = 16'h0000;
  localparam logic [15:0] PLL_TWO_MASK  = 16'h0F7F;

  // Page select.
  localparam logic [15:0] PAGE_MASK  = 16'h0007;
  localparam logic [15:0] PAGE_RESET = 16'h0000;

  // Context control.
  localparam int CTX_RESTART_BIT = 15;
  localparam int CTX_READ_BIT    = 3;
  localparam int CTX_VBLANK_BIT  = 1;
  localparam int CTX_HBLANK_BIT  = 0;
  localparam logic [15:0] CONTEXT_RESET = 16'h000B;
  // Bit 15 is kept only in the shared restart flop, never in the word.
  localparam logic [15:0] CONTEXT_MASK  = 16'h008F;
  localparam logic [15:0] RESTART_MASK  = 16'h0002;
  localparam int RESTART_REG_BIT = 1;

endpackage : sensor_pll_page_pkg

// *** src/byte_split_port.sv ***
`timescale 1ns/10ps
// Assembles two 8-bit transfers into a 16-bit access.
module byte_split_port
  import sensor_pll_page_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              resetn,
  input  wire logic              byteWrite,
  input  wire logic              byteRead,
  input  wire logic [7:0]        byteIn,
  input  wire logic [15:0]       wordRead,
  output logic      [7:0]        byteOut,
  output logic                   wordWrite,
  output logic      [15:0]       wordOut
);

  logic       phase_reg;
  logic [7:0] high_reg;
  logic [7:0] low_reg;

  // High byte goes first; the second byte completes the word.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      phase_reg <= 1'b0;
      high_reg  <= 8'h00;
      low_reg   <= 8'h00;
      byteOut   <= 8'h00;
      wordWrite <= 1'b0;
      wordOut   <= 16'h0000;
    end else begin
      wordWrite <= 1'b0;
      if (byteWrite) begin
        phase_reg <= ~phase_reg;
        if (!phase_reg) begin
          high_reg <= byteIn;
        end else begin
          wordOut   <= {high_reg, byteIn};
          wordWrite <= 1'b1;
        end
      end else if (byteRead) begin
        phase_reg <= ~phase_reg;
        if (!phase_reg) begin
          byteOut <= wordRead[15:8];
          low_reg <= wordRead[7:0];
        end else begin
          byteOut <= low_reg;
        end
      end
    end
  end

endmodule : byte_split_port

// *** src/sensor_pll_page_context_regs.sv ***
`timescale 1ns/10ps
// Behaviour
// - Ship clock force keeps gate running
// - Nonzero page redirects accesses elsewhere, except to the page register
// - Byte port gives 16-bit via bytes
// - Restart drops frame, resets first row
// - Restart bit shared with restart register
// - Read mode select picks context
// - B-only read mode bits from B
// - Vertical blank select picks context
// - Horizontal blank select picks context
// - Bypass takes external clock directly
module sensor_pll_page_context_regs
  import sensor_pll_page_pkg::*;
#(
  parameter logic [15:0] IDENT_VALUE = 16'h00A5
)(
  input  wire logic              core_clk,
  input  wire logic              resetn,
  input  wire logic              regWrite,
  input  wire logic              regRead,
  input  wire logic [7:0]        regAddr,
  input  wire logic [15:0]       regWdata,
  input  wire logic              byteMode,
  output logic      [15:0]       regRdata,
  output logic                   pageWrite,
  output logic                   pageRead,
  output logic      [2:0]        pageSel,
  input  wire logic [15:0]       pageRdata,
  input  wire logic              frameStart,
  input  wire logic              restartDone,
  input  wire logic [15:0]       readModeA,
  input  wire logic [15:0]       readModeB,
  input  wire logic [15:0]       readModeBOnlyMask,
  input  wire logic [15:0]       vblankA,
  input  wire logic [15:0]       vblankB,
  input  wire logic [15:0]       hblankA,
  input  wire logic [15:0]       hblankB,
  input  wire logic              external_clock_input,
  input  wire logic              pllClock,
  input  wire logic              shipGateReq,
  output logic                   shipClockEnable,
  output logic                   masterClockSel,
  output logic                   masterClock,
  output logic                   pllPowerDown,
  output logic                   pllStandbyPowerDown,
  output logic      [7:0]        pllMultiplier,
  output logic      [5:0]        pllPreDivider,
  output logic      [6:0]        pllPostDivider,
  output logic                   frameRestart,
  output logic      [15:0]       readModeActive,
  output logic      [15:0]       vblankActive,
  output logic      [15:0]       hblankActive
);

  logic [15:0] clock_reg;
  logic [15:0] pllOne_reg;
  logic [15:0] pllTwo_reg;
  logic [15:0] page_reg;
  logic [15:0] context_reg;
  logic        restart_reg;
  logic [2:0]  ctxShadow_reg;
  logic        sensorSel;
  logic        wrLocal;
  logic        rdLocal;
  logic        byteWr;
  logic        byteRd;
  logic        splitWrite;
  logic [15:0] splitWord;
  logic [7:0]  splitByte;
  logic [15:0] readWord;
  logic [15:0] localRead;
  logic        byteRdLast;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction : hit

  // Page register itself stays reachable from every page.
  // page redirect decode
  assign sensorSel = (page_reg[2:0] == 3'd0) || hit(regAddr, PAGE_OFFS);
  assign byteWr    = regWrite && hit(regAddr, BYTE_PORT_OFFS) && byteMode;
  assign byteRd    = regRead && hit(regAddr, BYTE_PORT_OFFS) && byteMode;
  assign wrLocal   = sensorSel && regWrite && !byteWr;
  assign rdLocal   = sensorSel && regRead;
  assign pageWrite = !sensorSel && regWrite;
  assign pageRead  = !sensorSel && regRead;
  assign pageSel   = page_reg[2:0];

  byte_split_port u_split (
    .core_clk  (core_clk),
    .resetn    (resetn),
    .byteWrite (sensorSel && byteWr),
    .byteRead  (sensorSel && byteRd),
    .byteIn    (regWdata[7:0]),
    .wordRead  (readWord),
    .byteOut   (splitByte),
    .wordWrite (splitWrite),
    .wordOut   (splitWord)
  );

  // The split word is written to the context register, the main target.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      clock_reg  <= CLOCK_RESET;
      pllOne_reg <= PLL_ONE_RESET;
      pllTwo_reg <= PLL_TWO_RESET;
      page_reg   <= PAGE_RESET;
    end else if (wrLocal) begin
      unique case (regAddr)
        CLOCK_OFFS:   clock_reg  <= regWdata & CLOCK_MASK;
        PLL_ONE_OFFS: pllOne_reg <= regWdata & PLL_ONE_MASK;
        PLL_TWO_OFFS: pllTwo_reg <= regWdata & PLL_TWO_MASK;
        PAGE_OFFS:    page_reg   <= regWdata & PAGE_MASK;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      context_reg <= CONTEXT_RESET;
    end else if (wrLocal && hit(regAddr, CONTEXT_OFFS)) begin
      context_reg <= regWdata & CONTEXT_MASK;
    end else if (splitWrite) begin
      context_reg <= splitWord & CONTEXT_MASK;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      restart_reg <= 1'b0;
    end else if (wrLocal && hit(regAddr, CONTEXT_OFFS)
                 && regWdata[CTX_RESTART_BIT]) begin
      restart_reg <= 1'b1;
    end else if (wrLocal && hit(regAddr, RESTART_OFFS)
                 && regWdata[RESTART_REG_BIT]) begin
      restart_reg <= 1'b1;
    end else if (splitWrite && splitWord[CTX_RESTART_BIT]) begin
      restart_reg <= 1'b1;
    end else if (restartDone) begin
      restart_reg <= 1'b0;
    end
  end

  assign frameRestart = restart_reg;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctxShadow_reg <= {CONTEXT_RESET[CTX_READ_BIT],
                        CONTEXT_RESET[CTX_VBLANK_BIT],
                        CONTEXT_RESET[CTX_HBLANK_BIT]};
    end else if (frameStart) begin
      ctxShadow_reg <= {context_reg[CTX_READ_BIT],
                        context_reg[CTX_VBLANK_BIT],
                        context_reg[CTX_HBLANK_BIT]};
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      readModeActive <= 16'h0000;
    end else begin
      readModeActive <= (ctxShadow_reg[2] ? readModeB : readModeA)
                        & ~readModeBOnlyMask
                        | (readModeB & readModeBOnlyMask);
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      vblankActive <= 16'h0000;
      hblankActive <= 16'h0000;
    end else begin
      vblankActive <= ctxShadow_reg[1] ? vblankB : vblankA;
      hblankActive <= ctxShadow_reg[0] ? hblankB : hblankA;
    end
  end

  assign shipClockEnable = shipGateReq || clock_reg[CLK_SHIP_BIT];
  assign masterClockSel  = clock_reg[CLK_BYPASS_BIT];
  assign masterClock     = masterClockSel ? external_clock_input : pllClock;
  assign pllPowerDown        = clock_reg[CLK_PLLPD_BIT];
  assign pllStandbyPowerDown = clock_reg[CLK_STBYPD_BIT];
  assign pllMultiplier  = pllOne_reg[15:8];
  assign pllPreDivider  = pllOne_reg[5:0];
  assign pllPostDivider = pllTwo_reg[6:0];

  always_comb begin
    unique case (regAddr)
      CLOCK_OFFS:     localRead = clock_reg;
      PLL_ONE_OFFS:   localRead = pllOne_reg;
      PLL_TWO_OFFS:   localRead = pllTwo_reg;
      PAGE_OFFS:      localRead = page_reg;
      BYTE_PORT_OFFS: localRead = context_reg
                                  | ({15'h0000, restart_reg} << 15);
      CONTEXT_OFFS:   localRead = context_reg
                                  | ({15'h0000, restart_reg} << 15);
      RESTART_OFFS:   localRead = {14'h0000, restart_reg, 1'b0};
      IDENT_OFFS:     localRead = IDENT_VALUE;
      default:        localRead = 16'h0000;
    endcase
  end

  assign readWord = localRead;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      byteRdLast <= 1'b0;
    end else begin
      byteRdLast <= sensorSel && byteRd;
    end
  end

  // Read data is registered; redirected reads pass the page data.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      regRdata <= 16'h0000;
    end else if (rdLocal && !byteRd) begin
      regRdata <= localRead;
    end else if (pageRead) begin
      regRdata <= pageRdata;
    end else if (byteRdLast) begin
      // A byte read lands one cycle after a word read would, since the
      // split port registers the byte before it reaches the bus.
      regRdata <= {8'h00, splitByte};
    end
  end

endmodule : sensor_pll_page_context_regs

// *** verification/pll_page_monitor.sv ***
`timescale 1ns/10ps
module pll_page_monitor
  import sensor_pll_page_pkg::*;
#(
  parameter logic [15:0] IDENT_VALUE = 16'h00A5
)(
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [7:0]  regAddr,
  input wire logic [15:0] regWdata,
  input wire logic [15:0] regRdata,
  input wire logic        pageWrite,
  input wire logic [2:0]  pageSel,
  input wire logic        restartDone,
  input wire logic        shipClockEnable,
  input wire logic        masterClockSel,
  input wire logic        masterClock,
  input wire logic        external_clock_input,
  input wire logic        pllClock,
  input wire logic [7:0]  pllMultiplier,
  input wire logic [5:0]  pllPreDivider,
  input wire logic        frameRestart
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  logic wrOk;
  // A nonzero page sends writes away from these registers, except writes to the page register.
  assign wrOk = regWrite && (pageSel == 3'h0);
  a_ship_force:
    assert property (wrOk && regAddr == CLOCK_OFFS && regWdata[0]
      |=> shipClockEnable) else $error("ship gate not forced on");
  a_pll_fields:
    assert property (wrOk && regAddr == PLL_ONE_OFFS |=>
      pllMultiplier == $past(regWdata[15:8])
      && pllPreDivider == $past(regWdata[5:0]))
      else $error("pll fields not loaded");
  a_page_redirect:
    assert property (regWrite && pageSel != 3'h0 && regAddr != PAGE_OFFS
      |-> pageWrite) else $error("write not redirected");
  a_restart_set:
    assert property (wrOk && regAddr == CONTEXT_OFFS && regWdata[15]
      |=> frameRestart) else $error("restart not set");
  a_restart_clear:
    assert property (restartDone && !regWrite |=> !frameRestart)
      else $error("restart not cleared");
  a_bypass_sel:
    assert property (wrOk && regAddr == CLOCK_OFFS
      |=> masterClockSel == $past(regWdata[15]))
      else $error("bypass select wrong");
  a_clock_mux:
    assert property (masterClock == (masterClockSel ?
      external_clock_input : pllClock)) else $error("master clock wrong");
  a_ident_read:
    assert property (regRead && pageSel == 3'h0 && regAddr == IDENT_OFFS
      |=> regRdata == IDENT_VALUE) else $error("ident read wrong");
endmodule : pll_page_monitor

bind sensor_pll_page_context_regs pll_page_monitor #(
  .IDENT_VALUE(IDENT_VALUE)
) pll_page_monitor_inst (
  .core_clk, .resetn, .regWrite, .regRead, .regAddr, .regWdata,
  .regRdata, .pageWrite, .pageSel, .restartDone, .shipClockEnable,
  .masterClockSel, .masterClock, .external_clock_input, .pllClock,
  .pllMultiplier, .pllPreDivider, .frameRestart
);

// *** verification/host_model.sv ***
`timescale 1ns/10ps
module host_model (
  input  wire logic        core_clk,
  output logic             regWrite,
  output logic             regRead,
  output logic [7:0]       regAddr,
  output logic [15:0]      regWdata,
  input  wire logic [15:0] regRdata
);
  initial begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 8'h00;
    regWdata = 16'h0000;
  end
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    #1;
    regWrite = 1'b1;
    regAddr = a;
    regWdata = d;
    @(posedge core_clk);
    #1;
    regWrite = 1'b0;
    // Idle bus shows inverted values so stale data never looks valid.
    regAddr = ~a;
    regWdata = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge core_clk);
    #1;
    regRead = 1'b1;
    regAddr = a;
    @(posedge core_clk);
    #1;
    regRead = 1'b0;
    regAddr = ~a;
    d = regRdata;
  endtask : rd
endmodule : host_model

// *** verification/tb.sv ***
`timescale 1ns/10ps
module tb;
  import sensor_pll_page_pkg::*;
  // Arbitrary identification value.
  localparam logic [15:0] IDENT = 16'h005A;
  localparam logic [15:0] SELS [4] = '{16'h0, 16'h8, 16'h2, 16'h1};
  logic core_clk = 1'b0, resetn = 1'b0, byteMode = 1'b0;
  logic frameStart = 1'b0, restartDone = 1'b0, shipGateReq = 1'b0;
  logic external_clock_input = 1'b0, pllClock = 1'b0;
  logic [15:0] pageRdata = 16'h5A5A, readModeBOnlyMask = 16'h00F0;
  logic [15:0] readModeA = 16'h1111, readModeB = 16'hEEEE;
  logic [15:0] vblankA = 16'h0101, vblankB = 16'h0202;
  logic [15:0] hblankA = 16'h0303, hblankB = 16'h0404;
  logic regWrite, regRead, pageWrite, pageRead, shipClockEnable;
  logic masterClockSel, masterClock, pllPowerDown, pllStandbyPowerDown;
  logic frameRestart;
  logic [7:0] regAddr, pllMultiplier;
  logic [15:0] regWdata, regRdata, readModeActive, vblankActive;
  logic [15:0] hblankActive;
  logic [2:0] pageSel;
  logic [5:0] pllPreDivider;
  logic [6:0] pllPostDivider;
  int errCount = 0, samplesChecked = 0, cycles = 0, pageHits = 0;
  int pageReadHits = 0;
  sensor_pll_page_context_regs #(.IDENT_VALUE(IDENT))
    sensor_pll_page_context_regs_inst (
    .core_clk, .resetn, .regWrite, .regRead, .regAddr, .regWdata,
    .byteMode, .regRdata, .pageWrite, .pageRead, .pageSel, .pageRdata,
    .frameStart, .restartDone, .readModeA, .readModeB, .readModeBOnlyMask,
    .vblankA, .vblankB, .hblankA, .hblankB, .external_clock_input,
    .pllClock, .shipGateReq, .shipClockEnable, .masterClockSel,
    .masterClock, .pllPowerDown, .pllStandbyPowerDown, .pllMultiplier,
    .pllPreDivider, .pllPostDivider, .frameRestart, .readModeActive,
    .vblankActive, .hblankActive);
  host_model host_model_inst (.core_clk, .regWrite, .regRead, .regAddr,
    .regWdata, .regRdata);
  always #20 core_clk = ~core_clk;
  always #7.3 external_clock_input = ~external_clock_input;
  always #9.1 pllClock = ~pllClock;
  always @(posedge core_clk) begin
    cycles++;
    if (pageWrite)
      pageHits++;
    if (pageRead)
      pageReadHits++;
    if (cycles == 4000) begin
      errCount++;
      testDone();
    end
  end
  task automatic testDone();
    $display("checks %0d mismatches %0d", samplesChecked, errCount);
    if (errCount == 0 && samplesChecked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : testDone
  task automatic chk(input logic [15:0] g, e, input string m);
    samplesChecked++;
    if (g !== e) begin
      errCount++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] a, input logic [15:0] e,
                     input string m);
    logic [15:0] d;
    host_model_inst.rd(a, d);
    chk(d, e, m);
  endtask : rdc
  task automatic byteRdc(input logic [15:0] e, input string m);
    logic [15:0] d;
    host_model_inst.rd(BYTE_PORT_OFFS, d);
    @(posedge core_clk);
    #1;
    chk(regRdata, e, m);
  endtask : byteRdc
  task automatic pulse(input logic f);
    @(posedge core_clk);
    #1;
    frameStart = f;
    restartDone = !f;
    @(posedge core_clk);
    #1;
    frameStart = 1'b0;
    restartDone = 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
  endtask : pulse
  task automatic t_reset();
    rdc(PLL_ONE_OFFS, 16'h1000, "pll one reset");
    rdc(PLL_TWO_OFFS, 16'h0000, "pll two reset");
    rdc(PAGE_OFFS, 16'h0000, "page reset");
    rdc(CONTEXT_OFFS, 16'h000B, "context reset");
    rdc(8'h10, 16'h0000, "unmapped read");
    chk(16'(masterClockSel), 16'h0001, "bypass reset");
    chk(16'(pllPowerDown), 16'h0001, "pll down reset");
    chk(16'(pllStandbyPowerDown), 16'h0001, "standby down reset");
  endtask : t_reset
  task automatic t_pll();
    host_model_inst.wr(PLL_ONE_OFFS, 16'h2A15);
    chk(16'(pllMultiplier), 16'h002A, "multiplier");
    chk(16'(pllPreDivider), 16'h0015, "pre divider");
    host_model_inst.wr(PLL_ONE_OFFS, 16'hFFFF);
    rdc(PLL_ONE_OFFS, 16'hFF3F, "pll one mask");
    host_model_inst.wr(PLL_TWO_OFFS, 16'h007F);
    chk(16'(pllPostDivider), 16'h007F, "post divider");
    host_model_inst.wr(IDENT_OFFS, 16'h0000);
    rdc(IDENT_OFFS, IDENT, "ident after write");
  endtask : t_pll
  task automatic t_clock();
    chk(16'(shipClockEnable), 16'h0000, "ship idle");
    host_model_inst.wr(CLOCK_OFFS, 16'h0001);
    chk(16'(shipClockEnable), 16'h0001, "ship forced");
    chk(16'(masterClockSel), 16'h0000, "pll chosen");
    chk(16'(pllPowerDown), 16'h0000, "pll powered");
    chk(16'(pllStandbyPowerDown), 16'h0000, "standby powered");
    host_model_inst.wr(CLOCK_OFFS, 16'hE000);
    chk(16'(shipClockEnable), 16'h0000, "ship gated");
    chk(16'(masterClockSel), 16'h0001, "bypass chosen");
    shipGateReq = 1'b1;
    #1;
    chk(16'(shipClockEnable), 16'h0001, "ship request");
    @(posedge core_clk);
    #1;
    shipGateReq = 1'b0;
  endtask : t_clock
  task automatic t_context();
    logic [15:0] p, rm;
    p = 16'h000B;
    for (int i = 0; i < 4; i++) begin
      readModeA = ~readModeA;
      vblankB = vblankB + 16'h0010;
      hblankA = hblankA + 16'h0010;
      host_model_inst.wr(CONTEXT_OFFS, SELS[i]);
      for (int k = 0; k < 2; k++) begin
        rm = (readModeA & ~readModeBOnlyMask)
           | (readModeB & readModeBOnlyMask);
        if (p[3])
          rm = readModeB;
        chk(readModeActive, rm, "read mode");
        chk(vblankActive, p[1] ? vblankB : vblankA, "vblank");
        chk(hblankActive, p[0] ? hblankB : hblankA, "hblank");
        p = SELS[i];
        if (k == 0)
          pulse(1'b1);
      end
    end
  endtask : t_context
  task automatic t_restart();
    host_model_inst.wr(CONTEXT_OFFS, 16'h8000);
    chk(16'(frameRestart), 16'h0001, "restart set");
    rdc(RESTART_OFFS, 16'h0002, "restart alias");
    pulse(1'b0);
    chk(16'(frameRestart), 16'h0000, "restart clear");
    rdc(CONTEXT_OFFS, 16'h0000, "restart clear view");
    host_model_inst.wr(RESTART_OFFS, 16'h0002);
    rdc(CONTEXT_OFFS, 16'h8000, "restart mirror");
    pulse(1'b0);
  endtask : t_restart
  task automatic t_page();
    host_model_inst.wr(PAGE_OFFS, 16'h0003);
    chk(16'(pageSel), 16'h0003, "page select");
    host_model_inst.wr(PLL_ONE_OFFS, 16'h1234);
    chk(16'(pageHits), 16'h0001, "page write");
    pageRdata = 16'hC3C3;
    rdc(PLL_ONE_OFFS, 16'hC3C3, "page read");
    chk(16'(pageReadHits), 16'h0001, "page read strobe");
    host_model_inst.wr(PAGE_OFFS, 16'h0000);
    rdc(PLL_ONE_OFFS, 16'hFF3F, "sensor untouched");
  endtask : t_page
  task automatic t_byte();
    byteMode = 1'b1;
    host_model_inst.wr(BYTE_PORT_OFFS, 16'h0000);
    host_model_inst.wr(BYTE_PORT_OFFS, 16'h0009);
    byteMode = 1'b0;
    rdc(CONTEXT_OFFS, 16'h0009, "byte pair");
    host_model_inst.wr(RESTART_OFFS, 16'h0002);
    byteMode = 1'b1;
    byteRdc(16'h0080, "byte read high");
    byteRdc(16'h0009, "byte read low");
    byteMode = 1'b0;
  endtask : t_byte
  initial begin
    repeat (12) @(posedge core_clk);
    #1;
    resetn = 1'b1;
    t_reset();
    t_pll();
    t_clock();
    t_context();
    t_restart();
    t_page();
    t_byte();
    resetn = 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    resetn = 1'b1;
    rdc(CONTEXT_OFFS, 16'h000B, "second reset");
    testDone();
  end
endmodule : tb
